// ==== src/ddrb_pkg.sv ====
package ddrb_pkg;
    // Default organisation: wide variant, nine-bit lanes
    localparam int DEF_DATA_W = 36;
    localparam int DEF_ADDR_W = 20;
    localparam int LANE_W = 9;
    // Stored address bits; the full array is far too big for flip-flops
    localparam int DEF_MEM_W = 4;
    // Read latency in link clock cycles, per timing mode
    localparam int LAT_PLL = 2;
    localparam int LAT_DDR1 = 1;
    // Controller clocks per half period of the link clock
    localparam int K_HALF_CLK = 2;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [1:0] PH_FALL_PREP = 2'h2;
    localparam logic [1:0] PH_RISE_HOLD = 2'h0;
    // Timing mode after reset: PLL running
    localparam logic RST_PLL_MODE = 1'h1;
    localparam logic [2:0] RST_PLL_SYNC = 3'h7;

    // Byte-lane write merge: a high select keeps the stored lane
    function automatic logic [DEF_DATA_W-1:0] lane_merge(
        input logic [DEF_DATA_W-1:0] old_word,
        input logic [DEF_DATA_W-1:0] new_word,
        input logic [DEF_DATA_W/LANE_W-1:0] sel_n
    );
        logic [DEF_DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < DEF_DATA_W / LANE_W; i++) begin
            if (!sel_n[i]) begin
                res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction
endpackage

// ==== src/ddrb_link_if.sv ====
`timescale 1ns/100ps
interface ddrb_link_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 20
);
    localparam int LANES = DATA_W / 9;
    // Link clock pair, made by the controller
    logic k;
    logic k_n;
    // Command and write path
    logic load_strobe_n;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] byte_write_select_n;
    logic [DATA_W-1:0] ctl_dq;
    logic ctl_dq_oe_n;
    // Read path
    logic [DATA_W-1:0] dev_dq;
    logic dev_dq_oe_n;
    logic output_valid_flag;
    logic echo_clock;
    logic echo_clock_n;
    // Resolved shared bus; a floating bus reads as zero
    logic [DATA_W-1:0] dq;

    assign dq = !dev_dq_oe_n ? dev_dq : (!ctl_dq_oe_n ? ctl_dq : '0);

    modport dev (
        input k, k_n, load_strobe_n, rw, addr, byte_write_select_n, dq,
        output dev_dq, dev_dq_oe_n, output_valid_flag, echo_clock,
        output echo_clock_n
    );
    modport ctl (
        output k, k_n, load_strobe_n, rw, addr, byte_write_select_n,
        output ctl_dq, ctl_dq_oe_n,
        input dq, output_valid_flag, echo_clock, echo_clock_n
    );
endinterface

// ==== src/ddrb_sram_dev.sv ====
`timescale 1ns/100ps
module ddrb_sram_dev
    import ddrb_pkg::*;
#(
    parameter int DATA_W = DEF_DATA_W,
    parameter int ADDR_W = DEF_ADDR_W,
    parameter int MEM_W = DEF_MEM_W
) (
    // Bench reset, sampled on the true link clock
    input wire logic rstn,
    // Static mode strap
    input wire logic pll_off_n,
    // Link
    ddrb_link_if.dev link
);
    localparam int LANES = DATA_W / LANE_W;
    localparam int DEPTH = 1 << MEM_W;

    // State clocked by the true link clock
    typedef struct packed {
        logic [2:0] pll_sync;
        logic pll_mode;
        logic wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic wr_commit;
        logic [ADDR_W-1:0] cm_addr;
        logic [DATA_W-1:0] w0;
        logic [LANES-1:0] w0_sel_n;
        logic [1:0] rd_v;
        logic [1:0][ADDR_W-1:0] rd_a;
        logic [DATA_W-1:0] q_rise;
        logic [DATA_W-1:0] q_next;
        logic v_rise;
        logic [DEPTH-1:0][1:0][DATA_W-1:0] mem;
    } ddrb_rise_t;

    // State clocked by the complement link clock
    typedef struct packed {
        logic [DATA_W-1:0] q_fall;
        logic v_fall;
        logic [DATA_W-1:0] w1;
        logic [LANES-1:0] w1_sel_n;
    } ddrb_fall_t;

    ddrb_rise_t r;
    ddrb_rise_t next_r;
    ddrb_fall_t f;
    ddrb_fall_t next_f;

    // Memory index from the low address bits; the map is a fixed function,
    // so any pin order the controller wires stays self-consistent
    function automatic logic [MEM_W-1:0] mem_index(
        input logic [ADDR_W-1:0] a
    );
        return a[MEM_W-1:0];
    endfunction

    // True clock: command, address, first words and the memory
    always_comb begin
        logic launch;
        logic [ADDR_W-1:0] launch_a;
        next_r = r;
        launch = 1'b0;
        launch_a = '0;
        // Strap passes three stages; a change counts once two agree
        next_r.pll_sync = {r.pll_sync[1:0], pll_off_n};
        if (r.pll_sync[1] == r.pll_sync[2]) begin
            next_r.pll_mode = r.pll_sync[2];
        end
        // Commit both words of a finished write burst
        next_r.wr_commit = 1'b0;
        if (r.wr_commit) begin
            next_r.mem[mem_index(r.cm_addr)][0] = lane_merge(
                r.mem[mem_index(r.cm_addr)][0], r.w0,
                r.w0_sel_n);
            next_r.mem[mem_index(r.cm_addr)][1] = lane_merge(
                r.mem[mem_index(r.cm_addr)][1], f.w1,
                f.w1_sel_n);
        end
        // First write word and its selects on the true clock
        next_r.wr_pend = 1'b0;
        if (r.wr_pend) begin
            next_r.w0 = link.dq;
            next_r.w0_sel_n = link.byte_write_select_n;
            next_r.cm_addr = r.wr_addr;
            next_r.wr_commit = 1'b1;
        end
        // Read pipeline; stage chosen by the timing mode
        next_r.rd_v = {r.rd_v[0], 1'b0};
        next_r.rd_a[1] = r.rd_a[0];
        if (r.pll_mode) begin
            launch = r.rd_v[LAT_PLL-1];
            launch_a = r.rd_a[LAT_PLL-1];
        end else begin
            launch = r.rd_v[LAT_DDR1-1];
            launch_a = r.rd_a[LAT_DDR1-1];
        end
        // Load strobe opens a burst only on the true clock
        if (!link.load_strobe_n) begin
            if (link.rw) begin
                next_r.rd_v[0] = 1'b1;
                next_r.rd_a[0] = link.addr;
            end else begin
                next_r.wr_pend = 1'b1;
                next_r.wr_addr = link.addr;
            end
        end
        // Launch word one now, hold word two for the complement clock
        next_r.v_rise = launch;
        if (launch) begin
            next_r.q_rise = r.mem[mem_index(launch_a)][0];
            next_r.q_next = r.mem[mem_index(launch_a)][1];
        end
    end

    // Complement clock: second word in or out, never a command
    always_comb begin
        next_f = f;
        next_f.v_fall = r.v_rise;
        if (r.v_rise) begin
            next_f.q_fall = r.q_next;
        end
        if (r.wr_commit) begin
            next_f.w1 = link.dq;
            next_f.w1_sel_n = link.byte_write_select_n;
        end
    end

    always_ff @(posedge link.k) begin
        if (!rstn) begin
            r <= '0;
            r.pll_sync <= RST_PLL_SYNC;
            r.pll_mode <= RST_PLL_MODE;
        end else begin
            r <= next_r;
        end
    end

    // Reset is the same bench level, seen on the other clock
    always_ff @(posedge link.k_n) begin
        if (!rstn) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    // Double-rate output: the clock level picks the half-cycle register,
    // which keeps both words and the valid flag on the echo edges
    assign link.dev_dq = link.k ? r.q_rise : f.q_fall;
    assign link.output_valid_flag = link.k ? r.v_rise : f.v_fall;
    // Drivers switch off by themselves outside read data
    assign link.dev_dq_oe_n = link.k ? !r.v_rise : !f.v_fall;
    // Echo clocks run free and follow the true clock
    assign link.echo_clock = link.k;
    assign link.echo_clock_n = link.k_n;
endmodule

// ==== src/ddrb_mem_ctl.sv ====
`timescale 1ns/100ps
module ddrb_mem_ctl
    import ddrb_pkg::*;
#(
    parameter int DATA_W = DEF_DATA_W,
    parameter int ADDR_W = DEF_ADDR_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata0,
    input wire logic [DATA_W-1:0] req_wdata1,
    input wire logic [DATA_W/LANE_W-1:0] req_sel0_n,
    input wire logic [DATA_W/LANE_W-1:0] req_sel1_n,
    // Read answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data0,
    output logic [DATA_W-1:0] rsp_data1,
    // Link
    ddrb_link_if.ctl link
);
    localparam int LANES = DATA_W / LANE_W;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_WDATA = 2'b10,
        ST_RDATA = 2'b11
    } ddrb_st_t;

    typedef struct packed {
        ddrb_st_t st;
        logic [1:0] ph;
        logic k;
        logic ld_n;
        logic rw;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] sel_n;
        logic [DATA_W-1:0] dq;
        logic oe_n;
        logic second;
        logic [DATA_W-1:0] w0;
        logic [DATA_W-1:0] w1;
        logic [LANES-1:0] s0_n;
        logic [LANES-1:0] s1_n;
        logic ready;
        logic rsp;
        logic [DATA_W-1:0] d0;
        logic [DATA_W-1:0] d1;
    } ddrb_ctl_t;

    ddrb_ctl_t s;
    ddrb_ctl_t next_s;

    // Strobe, data and lane pins change only mid-phase, half a phase clear of either link edge;
    // rw and addr load on a request at any phase, but only while the strobe is high,
    // so the memory never acts on a change at its sampling edge
    always_comb begin
        next_s = s;
        next_s.ph = s.ph + 2'h1;
        next_s.k = (next_s.ph < 2'(K_HALF_CLK));
        next_s.rsp = 1'b0;
        unique case (s.st)
            ST_IDLE: begin
                if (req_valid && s.ready) begin
                    next_s.ready = 1'b0;
                    next_s.rw = !req_write;
                    next_s.addr = req_addr;
                    next_s.w0 = req_wdata0;
                    next_s.w1 = req_wdata1;
                    next_s.s0_n = req_sel0_n;
                    next_s.s1_n = req_sel1_n;
                    next_s.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (s.ph == PH_FALL_PREP && s.ld_n) begin
                    next_s.ld_n = 1'b0;
                end else if (s.ph == PH_RISE_HOLD && !s.ld_n) begin
                    next_s.ld_n = 1'b1;
                    next_s.second = 1'b0;
                    next_s.st = s.rw ? ST_RDATA : ST_WDATA;
                end
            end
            ST_WDATA: begin
                if (s.ph == PH_FALL_PREP && !s.second && s.oe_n) begin
                    next_s.dq = s.w0;
                    next_s.sel_n = s.s0_n;
                    next_s.oe_n = 1'b0;
                end else if (s.ph == PH_RISE_HOLD && !s.oe_n) begin
                    next_s.dq = s.w1;
                    next_s.sel_n = s.s1_n;
                    next_s.second = 1'b1;
                end else if (s.ph == PH_FALL_PREP && s.second) begin
                    next_s.oe_n = 1'b1;
                    next_s.sel_n = '1;
                    next_s.ready = 1'b1;
                    next_s.st = ST_IDLE;
                end
            end
            ST_RDATA: begin
                // Sample mid-phase, well inside each data half-cycle
                if (s.ph == PH_RISE_HOLD && link.output_valid_flag) begin
                    next_s.d0 = link.dq;
                    next_s.second = 1'b1;
                end else if (s.ph == PH_FALL_PREP && s.second) begin
                    next_s.d1 = link.dq;
                    next_s.rsp = 1'b1;
                    next_s.ready = 1'b1;
                    next_s.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.ph <= PH_LAST;
            s.ld_n <= 1'b1;
            s.sel_n <= '1;
            s.oe_n <= 1'b1;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Link pins and answers, all from registers
    assign link.k = s.k;
    assign link.k_n = !s.k;
    assign link.load_strobe_n = s.ld_n;
    assign link.rw = s.rw;
    assign link.addr = s.addr;
    assign link.byte_write_select_n = s.sel_n;
    assign link.ctl_dq = s.dq;
    assign link.ctl_dq_oe_n = s.oe_n;
    assign req_ready = s.ready;
    assign rsp_valid = s.rsp;
    assign rsp_data0 = s.d0;
    assign rsp_data1 = s.d1;
endmodule

// ==== test/ddrb_link_chk.sv ====
`timescale 1ns/100ps
module ddrb_link_chk
    import ddrb_pkg::*;
#(
    parameter int DATA_W = DEF_DATA_W,
    parameter int ADDR_W = DEF_ADDR_W
) (
    // Device reset
    input wire logic rstn,
    // Link clocks and command
    input wire logic k,
    input wire logic k_n,
    input wire logic load_strobe_n,
    input wire logic rw,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W/9-1:0] byte_write_select_n,
    // Shared data bus and its drivers
    input wire logic [DATA_W-1:0] dq,
    input wire logic ctl_dq_oe_n,
    input wire logic dev_dq_oe_n,
    // Read timing outputs
    input wire logic output_valid_flag,
    input wire logic echo_clock,
    input wire logic echo_clock_n
);
    // Everything but the echo check is judged at the true link clock rise
    default clocking cb @(posedge k);
    endclocking
    default disable iff (!rstn);

    // Command kinds as sampled at a true clock rise
    sequence rd_load;
        !load_strobe_n && rw;
    endsequence
    sequence wr_load;
        !load_strobe_n && !rw;
    endsequence
    // Range covers both latency modes; second half is sampled at each rise
    sequence rd_burst;
        ##[2:3] output_valid_flag ##1 !output_valid_flag;
    endsequence

    a_echo_follows_k: assert property (
        @(negedge k) echo_clock && !echo_clock_n)
        else $error("echo clock pair not following link clock");
    a_valid_marks_drive: assert property (
        output_valid_flag == !dev_dq_oe_n)
        else $error("valid flag disagrees with read drive");
    a_read_burst: assert property (
        rd_load |-> rd_burst)
        else $error("read burst missing or too long");
    a_write_dev_quiet: assert property (
        wr_load |-> ##1 dev_dq_oe_n [*2])
        else $error("device drove bus during write");
    a_write_words: assert property (
        wr_load |-> ##1 !ctl_dq_oe_n ##1 ctl_dq_oe_n)
        else $error("write data window wrong length");
    a_idle_no_valid: assert property (
        load_strobe_n [*4] |-> !output_valid_flag)
        else $error("valid flag high with no read");
    a_no_bus_fight: assert property (
        !(!dev_dq_oe_n && !ctl_dq_oe_n))
        else $error("both ends drive the data bus");
    a_strobe_single: assert property (
        !load_strobe_n |-> ##1 load_strobe_n)
        else $error("load strobe held over two rises");
    a_lanes_idle: assert property (
        load_strobe_n [*4] |-> &byte_write_select_n)
        else $error("lane selects active while idle");
endmodule

// ==== test/ddr_burst2_sram_port_tb.sv ====
`timescale 1ns/100ps
module ddr_burst2_sram_port_tb
    import ddrb_pkg::*;
;
    typedef struct {
        logic wr;
        logic [19:0] addr;
        logic [35:0] d0;
        logic [35:0] d1;
        logic [3:0] m0;
        logic [3:0] m1;
    } ddrb_row_t;

    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic dev_rstn = 1'h0;
    logic pll_off_n = 1'h1;
    logic req_valid = 1'h0;
    logic req_write = 1'h0;
    logic [19:0] req_addr = 20'h0_0000;
    logic [35:0] req_wdata0 = '0;
    logic [35:0] req_wdata1 = '0;
    logic [3:0] req_sel0_n = 4'hF;
    logic [3:0] req_sel1_n = 4'hF;
    logic req_ready;
    logic rsp_valid;
    logic [35:0] rsp_data0;
    logic [35:0] rsp_data1;
    int fail_count = 0;
    int checked = 0;
    logic [35:0] model [16][2];
    // High address bits alias onto the 16 stored entries
    ddrb_row_t rows [12] = '{
        '{1'h1, 20'h0_0001, 36'h1_2345_6789, 36'hF_EDCB_A987, 4'h0, 4'h0},
        '{1'h1, 20'h0_0002, 36'hA_5A5A_5A5A, 36'h5_A5A5_A5A5, 4'h0, 4'h0},
        '{1'h1, 20'h8_0004, 36'hF_FFFF_FFFF, 36'h0_0000_0001, 4'h0, 4'h0},
        '{1'h0, 20'h0_0001, '0, '0, 4'hF, 4'hF},
        '{1'h0, 20'h0_0002, '0, '0, 4'hF, 4'hF},
        '{1'h1, 20'h0_0001, 36'h9_8765_4321, 36'h3_C3C3_C3C3, 4'hA, 4'h5},
        '{1'h0, 20'h0_0001, '0, '0, 4'hF, 4'hF},
        '{1'h1, 20'h0_0002, 36'h0_1111_2222, 36'h0_3333_4444, 4'hF, 4'hF},
        '{1'h0, 20'h0_0002, '0, '0, 4'hF, 4'hF},
        '{1'h0, 20'h8_0004, '0, '0, 4'hF, 4'hF},
        '{1'h0, 20'h0_0004, '0, '0, 4'hF, 4'hF},
        '{1'h0, 20'h0_0008, '0, '0, 4'hF, 4'hF}
    };

    // Controller makes the link clock from this one
    always #5 clock = ~clock;

    ddrb_link_if #(.DATA_W(36), .ADDR_W(20)) ddrb_link_if_i ();

    // Both ends and the checker run at their default widths
    ddrb_sram_dev ddrb_sram_dev_i (.rstn(dev_rstn), .pll_off_n(pll_off_n),
        .link(ddrb_link_if_i.dev));

    ddrb_mem_ctl ddrb_mem_ctl_i (
        .clock(clock), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
        .req_sel0_n(req_sel0_n), .req_sel1_n(req_sel1_n),
        .rsp_valid(rsp_valid), .rsp_data0(rsp_data0),
        .rsp_data1(rsp_data1), .link(ddrb_link_if_i.ctl));

    ddrb_link_chk ddrb_link_chk_i (
        .rstn(dev_rstn), .k(ddrb_link_if_i.k), .k_n(ddrb_link_if_i.k_n),
        .load_strobe_n(ddrb_link_if_i.load_strobe_n),
        .rw(ddrb_link_if_i.rw), .addr(ddrb_link_if_i.addr),
        .byte_write_select_n(ddrb_link_if_i.byte_write_select_n),
        .dq(ddrb_link_if_i.dq), .ctl_dq_oe_n(ddrb_link_if_i.ctl_dq_oe_n),
        .dev_dq_oe_n(ddrb_link_if_i.dev_dq_oe_n),
        .output_valid_flag(ddrb_link_if_i.output_valid_flag),
        .echo_clock(ddrb_link_if_i.echo_clock),
        .echo_clock_n(ddrb_link_if_i.echo_clock_n));

    task chk(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Device reset outlasts the controller's so it sees link clock rises
    task do_reset;
        @(posedge clock);
        rstn <= 1'h0;
        dev_rstn <= 1'h0;
        repeat (5) @(posedge clock);
        rstn <= 1'h1;
        repeat (12) @(posedge clock);
        dev_rstn <= 1'h1;
        repeat (8) @(posedge clock);
        foreach (model[i, j]) model[i][j] = '0;
        chk({34'h0, req_ready, rsp_valid}, 36'h0_0000_0002);
    endtask

    // One request, held for one clock, then a bounded wait for completion
    task xfer(input ddrb_row_t r);
        int n;
        @(posedge clock);
        req_valid <= 1'h1;
        req_write <= r.wr;
        req_addr <= r.addr;
        req_wdata0 <= r.d0;
        req_wdata1 <= r.d1;
        req_sel0_n <= r.m0;
        req_sel1_n <= r.m1;
        @(posedge clock);
        req_valid <= 1'h0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!(r.wr ? req_ready : rsp_valid) && n < 60);
        chk(36'(n < 60), 36'h0_0000_0001);
        for (int e = 0; e < 4; e++) begin
            if (r.wr && !r.m0[e]) begin
                model[r.addr[3:0]][0][e*9 +: 9] = r.d0[e*9 +: 9];
            end
            if (r.wr && !r.m1[e]) begin
                model[r.addr[3:0]][1][e*9 +: 9] = r.d1[e*9 +: 9];
            end
        end
        if (!r.wr) begin
            chk(rsp_data0, model[r.addr[3:0]][0]);
            chk(rsp_data1, model[r.addr[3:0]][1]);
        end
    endtask

    // Table pass in PLL mode, again in short latency mode, then a reset
    initial begin
        do_reset();
        foreach (rows[i]) xfer(rows[i]);
        pll_off_n <= 1'h0;
        repeat (32) @(posedge clock);
        foreach (rows[i]) xfer(rows[i]);
        do_reset();
        xfer(rows[3]);
        test_done();
    end

    // Whole run needs a few hundred clocks; this is far beyond it
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule
